// File: rtl/pwm_autoreload_timer.v
// Purpose: 8-bit PWM auto-reload timer with prescaler, capture and PWM
// Assumes: Classic Wishbone slave, 32-bit data, one-cycle registered ack
// Notes:   Registers at byte address 4 * index; low 8 bits carry data
// Function
// - Counter increments on each prescaler tick
// - Overflow reloads counter, prescaler untouched
// - Counter access register reads/writes live count
// - Divide input by two to the code
// - Bit 7 selects CPU or external clock
// - Enable bit 3 clear freezes counter and prescaler
// - Reset clears counter, prescaler, selects CPU clock
// - Force reload bit loads, clears prescaler, reads zero
// - Counter write also clears the prescaler
// - Hidden compare loaded from duty at overflow
// - Output enable drives PWM pin push-pull
// - Period is counter clock times 256 minus reload
// - Overflow sets inverse of polarity bit, compare sets polarity bit
// - PWM generation stops during HALT
// - Overflow sets sticky flag, enabled interrupt
// - External mode flags after 256 minus reload events
// - HALT with external clock freezes controls, counts
// - Capture edge latches counter, sets flag
// - Capture blocked until register is read
// - Capture interrupt while flag and enable set
// - Capture edges with their interrupt enabled act as HALT wake sources
// - Reading control register clears overflow flag
// - Edge select zero falling, one rising
// - Reading capture register clears its flag
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_art_defines.vh"
module pwm_autoreload_timer (
  // Clock and reset
  input  wire        i_ref_clk,
  input  wire        i_reset_n,
  // Wishbone slave
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [9:0]  i_wb_adr,
  input  wire [3:0]  i_wb_sel,
  input  wire [31:0] i_wb_dat,
  output reg  [31:0] o_wb_dat,
  output reg         o_wb_ack,
  // System
  input  wire        i_halt,
  // Pins
  input  wire        i_external_clock_in,
  input  wire [1:0]  i_capture_input_pin,
  output reg  [3:0]  o_pwm_output_pin,
  output reg  [3:0]  o_pwm_output_pin_oe,
  // Interrupt requests
  output reg         o_overflow_irq,
  output reg  [1:0]  o_capture_irq,
  output reg         o_wakeup
);
  // Control state
  reg  [7:0] duty_q [0:3];
  reg  [7:0] pwm_ctl_q;
  reg  [7:0] csr_q;
  reg  [7:0] arr_q;
  reg  [5:0] cap_csr_q;
  reg  [7:0] cap_val_q [0:1];
  reg  [7:0] cnt_q;
  reg  [6:0] presc_q;
  reg  [7:0] cnt_d;
  reg  [6:0] presc_d;
  reg  [31:0] rd_d;
  integer    k;

  // Input synchronisers; two flops per pin keep a metastable level
  // out of the edge logic
  wire       ext_lvl;
  wire       ext_rise;
  wire [1:0] cap_rise;
  wire [1:0] cap_fall;
  wire [1:0] cap_lvl;
  art_sync_edge u_ext (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_external_clock_in),
    .o_level   (ext_lvl),
    .o_rise    (ext_rise),
    .o_fall    ()
  );
  art_sync_edge u_cap0 (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_capture_input_pin[0]),
    .o_level   (cap_lvl[0]),
    .o_rise    (cap_rise[0]),
    .o_fall    (cap_fall[0])
  );
  art_sync_edge u_cap1 (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_capture_input_pin[1]),
    .o_level   (cap_lvl[1]),
    .o_rise    (cap_rise[1]),
    .o_fall    (cap_fall[1])
  );

  // Field views
  wire       clock_source_select = csr_q[`ART_CSR_CLOCK_SOURCE_SELECT];
  wire [2:0] clock_divide_select = csr_q[`ART_CSR_CC_HI:`ART_CSR_CC_LO];
  wire       counter_run_enable  = csr_q[`ART_CSR_TCE];
  wire       overflow_irq_enable = csr_q[`ART_CSR_OIE];
  wire       overflow_flag       = csr_q[`ART_CSR_OVF];
  wire [1:0] capture_edge_select = cap_csr_q[5:4];
  wire [1:0] capture_irq_enable  = cap_csr_q[3:2];
  wire [1:0] capture_flag        = cap_csr_q[1:0];

  // Bus decode; ack is a flop, and masking the take while it is high
  // keeps a request that the master still holds from being taken twice
  wire       bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire [7:0] reg_idx = i_wb_adr[9:2];
  wire       wr      = bus_req & i_wb_we & i_wb_sel[0];
  wire       rd      = bus_req & ~i_wb_we;
  // HALT with external clock freezes the control registers
  wire       ctl_frz = i_halt & clock_source_select;

  function hit;
    input [7:0] idx;
    input [7:0] want;
    begin
      hit = (idx == want);
    end
  endfunction

  // Tap select: prescaler carry into bit n marks a tick of 2^n
  function tap_tick;
    input [6:0] pre;
    input [2:0] sel;
    reg   [7:0] mask;
    begin
      mask     = (8'h01 << sel) - 8'h01;
      tap_tick = ((({1'b0, pre}) & mask) == mask);
    end
  endfunction

  // Sticky flag: a hardware event in the same cycle beats the clear
  function flag_next;
    input cur;
    input set;
    input clr;
    begin
      flag_next = set | (cur & ~clr);
    end
  endfunction

  // Edge select: one picks the rising edge, zero the falling edge
  function sel_edge;
    input want_rise;
    input rise;
    input fall;
    begin
      sel_edge = want_rise ? rise : fall;
    end
  endfunction

  // Clock input: CPU clock every cycle or a synchronised external edge
  wire in_tick  = clock_source_select ? ext_rise : 1'b1;
  wire run      = counter_run_enable & in_tick;
  wire cnt_tick = run & tap_tick(presc_q, clock_divide_select);
  // PWM and capture halt when HALT is on with CPU clock
  wire cpu_halt = i_halt & ~clock_source_select;
  wire step     = cnt_tick & ~cpu_halt;
  wire ovf      = step & (cnt_q == `ART_CNT_MAX);

  wire force_rl = wr & hit(reg_idx, `ART_IDX_CSR) &
                  i_wb_dat[`ART_CSR_FORCE_RELOAD] & ~ctl_frz;
  wire car_wr   = wr & hit(reg_idx, `ART_IDX_CAR) & ~ctl_frz;

  // Counter and prescaler next state; a software load overrides a count
  // step in the same cycle, and a force reload overrides a counter write
  always @* begin
    cnt_d   = cnt_q;
    presc_d = presc_q;
    if (run && !cpu_halt) begin
      presc_d = presc_q + 7'h01;
    end
    if (step) begin
      if (ovf) begin
        cnt_d = arr_q;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
    if (force_rl) begin
      cnt_d   = arr_q;
      presc_d = 7'h00;
    end else if (car_wr) begin
      cnt_d   = i_wb_dat[7:0];
      presc_d = 7'h00;
    end
  end

  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q   <= `ART_RESET_VAL;
      presc_q <= 7'h00;
    end else begin
      cnt_q   <= cnt_d;
      presc_q <= presc_d;
    end
  end

  // Capture edge qualification
  wire [1:0] cap_edge;
  assign cap_edge[0] = sel_edge(capture_edge_select[0],
                                cap_rise[0], cap_fall[0]);
  assign cap_edge[1] = sel_edge(capture_edge_select[1],
                                cap_rise[1], cap_fall[1]);
  wire [1:0] cap_rd;
  assign cap_rd[0] = rd & hit(reg_idx, `ART_IDX_CAP1);
  assign cap_rd[1] = rd & hit(reg_idx, `ART_IDX_CAP2);
  wire [1:0] cap_take = cap_edge & ~capture_flag;
  // Capture freezes in HALT with the CPU clock, as the counter does
  wire [1:0] cap_set  = cap_take & {2{~cpu_halt}};
  wire       csr_rd   = rd & hit(reg_idx, `ART_IDX_CSR);

  // Register file
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (k = 0; k < 4; k = k + 1) begin
        duty_q[k] <= `ART_RESET_VAL;
      end
      cap_val_q[0] <= `ART_RESET_VAL;
      cap_val_q[1] <= `ART_RESET_VAL;
      pwm_ctl_q    <= `ART_RESET_VAL;
      csr_q        <= `ART_RESET_VAL;
      arr_q        <= `ART_RESET_VAL;
      cap_csr_q    <= 6'h00;
    end else begin
      if (wr && !ctl_frz) begin
        case (reg_idx)
          `ART_IDX_DUTY3:  duty_q[3] <= i_wb_dat[7:0];
          `ART_IDX_DUTY2:  duty_q[2] <= i_wb_dat[7:0];
          `ART_IDX_DUTY1:  duty_q[1] <= i_wb_dat[7:0];
          `ART_IDX_DUTY0:  duty_q[0] <= i_wb_dat[7:0];
          `ART_IDX_PWMCTL: pwm_ctl_q <= i_wb_dat[7:0];
          `ART_IDX_ARR:    arr_q     <= i_wb_dat[7:0];
          `ART_IDX_CAPCSR: cap_csr_q[5:2] <= i_wb_dat[5:2];
          default: begin
          end
        endcase
        if (hit(reg_idx, `ART_IDX_CSR)) begin
          // Force reload bit is not stored, so it reads as zero
          csr_q[7:3] <= i_wb_dat[7:3];
          csr_q[`ART_CSR_OIE] <= i_wb_dat[`ART_CSR_OIE];
        end
      end
      // Overflow flag: set wins over the read clear
      csr_q[`ART_CSR_OVF] <= flag_next(overflow_flag, ovf,
                                       csr_rd);
      for (k = 0; k < 2; k = k + 1) begin
        if (cap_set[k]) begin
          cap_val_q[k] <= cnt_q;
        end
        cap_csr_q[k] <= flag_next(capture_flag[k], cap_set[k],
                                  cap_rd[k]);
      end
    end
  end

  // Read mux: unmapped indexes and reserved bits read as zero, and the
  // data stands in its flop until the next read
  always @* begin
    rd_d = 32'h0000_0000;
    case (reg_idx)
      `ART_IDX_DUTY3:  rd_d[7:0] = duty_q[3];
      `ART_IDX_DUTY2:  rd_d[7:0] = duty_q[2];
      `ART_IDX_DUTY1:  rd_d[7:0] = duty_q[1];
      `ART_IDX_DUTY0:  rd_d[7:0] = duty_q[0];
      `ART_IDX_PWMCTL: rd_d[7:0] = pwm_ctl_q;
      `ART_IDX_CSR:    rd_d[7:0] = {csr_q[7:3], 1'b0, csr_q[1:0]};
      `ART_IDX_CAR:    rd_d[7:0] = cnt_q;
      `ART_IDX_ARR:    rd_d[7:0] = arr_q;
      `ART_IDX_CAPCSR: rd_d[7:0] = {2'b00, cap_csr_q};
      `ART_IDX_CAP1:   rd_d[7:0] = cap_val_q[0];
      `ART_IDX_CAP2:   rd_d[7:0] = cap_val_q[1];
      default:         rd_d = 32'h0000_0000;
    endcase
  end

  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= bus_req;
      if (rd) begin
        o_wb_dat <= rd_d;
      end
    end
  end

  // PWM channels; each compares the next count, so that raw_q
  // changes in step with the counter value that matches its compare; o_pwm follows a cycle later and the pin flop a cycle after that
  wire [3:0] pwm_raw;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_pwm
      art_pwm_channel u_ch (
        .i_ref_clk  (i_ref_clk),
        .i_reset_n  (i_reset_n),
        .i_ovf      (ovf),
        .i_step     (step),
        .i_next_cnt (cnt_d),
        .i_duty     (duty_q[g]),
        .i_polarity (pwm_ctl_q[g]),
        .i_halt     (i_halt),
        .o_pwm      (pwm_raw[g])
      );
    end
  endgenerate

  // Wake sources: an overflow wakes only while the external clock counts
  wire       ovf_wake = ovf & overflow_irq_enable &
                        clock_source_select;
  wire       cap_wake = |(cap_edge & capture_irq_enable);

  // Pin and interrupt outputs; a pin reads low while its drive is off
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pwm_output_pin    <= 4'h0;
      o_pwm_output_pin_oe <= 4'h0;
      o_overflow_irq      <= 1'b0;
      o_capture_irq       <= 2'b00;
      o_wakeup            <= 1'b0;
    end else begin
      o_pwm_output_pin    <= pwm_raw & pwm_ctl_q[7:4];
      o_pwm_output_pin_oe <= pwm_ctl_q[7:4];
      o_overflow_irq      <= overflow_flag & overflow_irq_enable;
      o_capture_irq       <= capture_flag & capture_irq_enable;
      o_wakeup            <= i_halt & (ovf_wake | cap_wake);
    end
  end

  wire unused_ok = &{1'b0, ext_lvl, cap_lvl, i_wb_sel[3:1],
                     i_wb_dat[31:8]};
endmodule // pwm_autoreload_timer
`default_nettype wire

// File: rtl/pwm_art_defines.vh
// Purpose: Offsets, field positions and reset values of the auto-reload timer
// Assumes: Wishbone word addressing, one 8-bit register per 32-bit word
// Notes:   Byte address = 4 * register index
`ifndef PWM_ART_DEFINES_VH
`define PWM_ART_DEFINES_VH

`define ART_IDX_DUTY3      8'h73
`define ART_IDX_DUTY2      8'h74
`define ART_IDX_DUTY1      8'h75
`define ART_IDX_DUTY0      8'h76
`define ART_IDX_PWMCTL     8'h77
`define ART_IDX_CSR        8'h78
`define ART_IDX_CAR        8'h79
`define ART_IDX_ARR        8'h7a
`define ART_IDX_CAPCSR     8'h7b
`define ART_IDX_CAP1       8'h7c
`define ART_IDX_CAP2       8'h7d

`define ART_CSR_CLOCK_SOURCE_SELECT       7
`define ART_CSR_CC_HI      6
`define ART_CSR_CC_LO      4
`define ART_CSR_TCE        3
`define ART_CSR_FORCE_RELOAD       2
`define ART_CSR_OIE        1
`define ART_CSR_OVF        0

`define ART_CAP_CS_LO      4
`define ART_CAP_CIE_LO     2
`define ART_CAP_CF_LO      0

`define ART_RESET_VAL      8'h00
`define ART_PRESC_W        7
`define ART_CNT_MAX        8'hff

`endif

// File: rtl/art_sync_edge.v
// Purpose: Two-flop synchroniser with rise and fall pulses
// Assumes: Single clock domain
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module art_sync_edge (
  // Clock and reset
  input  wire i_ref_clk,
  input  wire i_reset_n,
  // Pin and edges
  input  wire i_pin,
  output wire o_level,
  output wire o_rise,
  output wire o_fall
);
  reg meta_q;
  reg sync_q;
  reg last_q;

  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_rise  = sync_q & ~last_q;
  assign o_fall  = ~sync_q & last_q;
endmodule // art_sync_edge
`default_nettype wire

// File: rtl/art_pwm_channel.v
// Purpose: One PWM channel with hidden compare register
// Assumes: Overflow and count-step strobes come from the timer core
// Notes:   Output is registered
`timescale 1ns/1ps
`default_nettype none
`include "pwm_art_defines.vh"
module art_pwm_channel (
  // Clock and reset
  input  wire       i_ref_clk,
  input  wire       i_reset_n,
  // Timer state
  input  wire       i_ovf,
  input  wire       i_step,
  input  wire [7:0] i_next_cnt,
  input  wire [7:0] i_duty,
  input  wire       i_polarity,
  input  wire       i_halt,
  // Output
  output reg        o_pwm
);
  reg [7:0] cmp_q;
  reg       raw_q;

  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmp_q <= `ART_RESET_VAL;
      raw_q <= 1'b0;
      o_pwm <= 1'b0;
    end else begin
      if (i_ovf) begin
        cmp_q <= i_duty;
        raw_q <= 1'b1;
      end else if (i_step && i_next_cnt == cmp_q) begin
        raw_q <= 1'b0;
      end
      if (!i_halt) begin
        o_pwm <= raw_q ^ i_polarity;
      end
    end
  end
endmodule // art_pwm_channel
`default_nettype wire

// File: verif/pwm_autoreload_timer_assertions.sv
// Purpose: Port-level checks of the auto-reload timer
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to every timer instance
`timescale 1ns/1ps
`default_nettype none
module art_checker (
  // Clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_reset_n,
  // Bus and system
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_halt,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  // Pins and requests
  input wire logic [3:0]  o_pwm_output_pin,
  input wire logic [3:0]  o_pwm_output_pin_oe,
  input wire logic        o_overflow_irq,
  input wire logic [1:0]  o_capture_irq,
  input wire logic        o_wakeup
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  wire req = i_wb_cyc && i_wb_stb;

  AST_ACK_LAT: assert property (
    req && !o_wb_ack |=> o_wb_ack) else $error("ack late");
  AST_ACK_PULSE: assert property (
    o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  AST_DAT_HI: assert property (
    o_wb_ack |-> o_wb_dat[31:8] == 24'h0) else $error("high bits set");
  // Only a bus access may drop a pending request
  AST_OVF_HOLD: assert property (
    o_overflow_irq && !req |=> o_overflow_irq)
    else $error("overflow request lost");
  AST_CAP_HOLD: assert property (
    !req |=> (o_capture_irq & $past(o_capture_irq)) ==
      $past(o_capture_irq)) else $error("capture request lost");
  AST_PWM_HALT: assert property (
    (i_halt && !i_wb_cyc) [*4] |=> $stable(o_pwm_output_pin))
    else $error("pwm moved in halt");
  AST_OE_HOLD: assert property (
    !i_wb_cyc [*3] |=> $stable(o_pwm_output_pin_oe))
    else $error("enable moved");
  AST_WAKE_HALT: assert property (
    o_wakeup |-> $past(i_halt)) else $error("wake outside halt");
  AST_WAKE_PULSE: assert property (
    o_wakeup |=> !o_wakeup) else $error("wake too long");
endmodule // art_checker

bind pwm_autoreload_timer art_checker u_chk (
  .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_halt(i_halt),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .o_pwm_output_pin(o_pwm_output_pin),
  .o_pwm_output_pin_oe(o_pwm_output_pin_oe),
  .o_overflow_irq(o_overflow_irq), .o_capture_irq(o_capture_irq),
  .o_wakeup(o_wakeup));
`default_nettype wire

// File: verif/art_pin_model.sv
// Purpose: Pin-side world: event clock source and capture signals
// Assumes: Edges slow enough for the input synchronisers
// Notes:   Event clock stands low between bursts
`timescale 1ns/1ps
`default_nettype none
module art_pin_model (
  // Clock
  input  wire logic       i_ref_clk,
  // Pins towards the timer
  output var  logic       o_ext_clk,
  output var  logic [1:0] o_cap
);
  initial begin
    o_ext_clk = 1'b0;
    o_cap = 2'b00;
  end
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge i_ref_clk) o_ext_clk <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      o_ext_clk <= 1'b0;
      repeat (4) @(posedge i_ref_clk);
    end
  endtask
  task automatic cap(input logic [1:0] v);
    @(posedge i_ref_clk) o_cap <= v;
    repeat (6) @(posedge i_ref_clk);
  endtask
endmodule // art_pin_model
`default_nettype wire

// File: verif/tb_pwm_autoreload_timer.sv
// Purpose: Register-level tests of the auto-reload timer
// Assumes: Ack one cycle after the take edge
// Notes:   Counts compared as differences to cancel pipeline delay
`timescale 1ns/1ps
`default_nettype none
`include "pwm_art_defines.vh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  n_errors++; $display("Error %s exp %h got %h", nm, e, g); end end
module tb_pwm_autoreload_timer;
  localparam logic [7:0] CSR = `ART_IDX_CSR;
  localparam logic [7:0] CAR = `ART_IDX_CAR;
  localparam logic [7:0] ARR = `ART_IDX_ARR;
  localparam logic [7:0] CAP = `ART_IDX_CAPCSR;
  logic        i_ref_clk = 1'b0;
  logic        i_reset_n;
  logic        i_wb_cyc;
  logic        i_wb_stb;
  logic        i_wb_we;
  logic [9:0]  i_wb_adr;
  logic [3:0]  i_wb_sel;
  logic [31:0] i_wb_dat;
  logic        i_halt;
  wire  [31:0] o_wb_dat;
  wire         o_wb_ack, ext_clk, o_overflow_irq, o_wakeup;
  wire  [1:0]  cap_pin, o_capture_irq;
  wire  [3:0]  pin, pin_oe;
  int          n_errors = 0, comparisons = 0, cyc_n = 0, n_wake = 0;
  int          h[4];
  always #2.5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cyc_n <= cyc_n + 1;
    if (o_wakeup === 1'b1) n_wake <= n_wake + 1;
  end
  pwm_autoreload_timer DUT (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_halt(i_halt),
    .i_external_clock_in(ext_clk), .i_capture_input_pin(cap_pin),
    .o_pwm_output_pin(pin), .o_pwm_output_pin_oe(pin_oe),
    .o_overflow_irq(o_overflow_irq), .o_capture_irq(o_capture_irq),
    .o_wakeup(o_wakeup));
  art_pin_model u_pins (.i_ref_clk(i_ref_clk), .o_ext_clk(ext_clk),
    .o_cap(cap_pin));
  task automatic end_of_test;
    $display("Counts: %0d compared, %0d mismatched", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] i, input logic [7:0] d,
                    input logic s, output logic [7:0] q);
    int t;
    @(posedge i_ref_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= {i, 2'b00};
    i_wb_sel <= {3'b000, s};
    i_wb_dat <= {24'h0, d};
    t = 0;
    do begin
      @(posedge i_ref_clk);
      t++;
    end while (o_wb_ack !== 1'b1 && t < 50);
    if (t >= 50) n_errors++;
    q = o_wb_dat[7:0];
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, i, d, 1'b1, q);
  endtask
  task automatic rd(input logic [7:0] i, output logic [7:0] q);
    wb(1'b0, i, 8'h00, 1'b1, q);
  endtask
  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    logic [7:0] q;
    rd(i, q);
    `CHK($sformatf("reg %h", i), e, q)
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic wait_ovf(output int at);
    int t;
    t = 0;
    do begin
      @(posedge i_ref_clk);
      t++;
    end while (o_overflow_irq !== 1'b1 && t < 300);
    if (t >= 300) n_errors++;
    at = cyc_n;
  endtask
  task automatic count_hi;
    h = '{default: 0};
    repeat (32) begin
      @(posedge i_ref_clk);
      for (int b = 0; b < 4; b++) h[b] += (pin[b] === 1'b1);
    end
  endtask
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    n_errors++;
    end_of_test();
  end
  initial begin
    logic [7:0] v, c1;
    int t0, t1, n0;
    i_reset_n <= 1'b0;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we <= 1'b0;
    i_wb_adr <= 10'h000;
    i_wb_sel <= 4'h0;
    i_wb_dat <= 32'h0;
    i_halt <= 1'b0;
    repeat (5) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    for (int i = 8'h73; i <= 8'h7d; i++) rc(i[7:0], 8'h00);
    `CHK("oe", 4'h0, pin_oe)
    wr(ARR, 8'h55);
    wr(CAR, 8'h12);
    rc(CAR, 8'h12);
    wr(8'h00, 8'h5a);
    rc(8'h00, 8'h00);
    wb(1'b1, ARR, 8'h66, 1'b0, v);
    rc(ARR, 8'h55);
    wr(CSR, 8'h04);
    rc(CAR, 8'h55);
    rc(CSR, 8'h00);
    $display("Test registers done");
    for (int k = 0; k < 8; k++) begin
      for (int j = 0; j < 2; j++) begin
        wr(CAR, 8'h00);
        wr(CSR, {1'b0, k[2:0], 4'h8});
        idle(4 + j * 3 * (1 << k));
        wr(CSR, {1'b0, k[2:0], 4'h0});
        rd(CAR, v);
        if (j == 0) c1 = v;
      end
      `CHK("ticks", 8'h03, (v - c1))
    end
    idle(20);
    rc(CAR, v);
    $display("Test prescaler done");
    wr(ARR, 8'hf0);
    wr(CSR, 8'h0e);
    wait_ovf(t0);
    rc(CSR, 8'h0b);
    rd(CAR, v);
    `CHK("reload", 4'hf, v[7:4])
    wait_ovf(t1);
    `CHK("period", 16, t1 - t0)
    wr(CSR, 8'h08);
    idle(40);
    `CHK("irq", 1'b0, o_overflow_irq)
    rc(CSR, 8'h09);
    $display("Test overflow done");
    wr(CSR, 8'h00);
    wr(8'h76, 8'hf8);
    wr(8'h75, 8'hf4);
    wr(`ART_IDX_PWMCTL, 8'h32);
    wr(CSR, 8'h0c);
    idle(40);
    count_hi();
    `CHK("oe", 4'h3, pin_oe)
    `CHK("hi0", 16, h[0])
    `CHK("hi1", 24, h[1])
    `CHK("hi2", 0, h[2])
    wr(8'h76, 8'hfc);
    idle(40);
    count_hi();
    `CHK("hi0", 24, h[0])
    i_halt <= 1'b1;
    idle(4);
    v = {4'h0, pin};
    idle(26);
    `CHK("halt", v[3:0], pin)
    i_halt <= 1'b0;
    $display("Test pwm done");
    wr(CSR, 8'h00);
    wr(CAR, 8'h42);
    wr(CAP, 8'h1c);
    u_pins.cap(2'b10);
    rc(CAP, 8'h1c);
    u_pins.cap(2'b11);
    `CHK("cirq", 2'b01, o_capture_irq)
    wr(CAR, 8'h43);
    u_pins.cap(2'b01);
    u_pins.cap(2'b00);
    u_pins.cap(2'b01);
    rc(CAP, 8'h1f);
    rc(8'h7c, 8'h42);
    rc(CAP, 8'h1e);
    wr(8'h7d, 8'hff);
    rc(8'h7d, 8'h43);
    idle(3);
    `CHK("cirq", 2'b00, o_capture_irq)
    $display("Test capture done");
    wr(ARR, 8'hfd);
    wr(CSR, 8'h8e);
    idle(20);
    rd(CSR, v);
    rc(CAR, 8'hfd);
    u_pins.pulses(2);
    rc(CSR, 8'h8a);
    u_pins.pulses(1);
    rc(CSR, 8'h8b);
    i_halt <= 1'b1;
    wr(CSR, 8'h00);
    n0 = n_wake;
    u_pins.pulses(3);
    `CHK("wake", n0 + 1, n_wake)
    u_pins.cap(2'b00);
    u_pins.cap(2'b01);
    `CHK("wake", n0 + 2, n_wake)
    i_halt <= 1'b0;
    rc(CSR, 8'h8b);
    $display("Test external done");
    end_of_test();
  end
endmodule // tb_pwm_autoreload_timer
`default_nettype wire
